// ==== asq_sequencer_control.sv ====
// sequencer control for one shared 12-bit sampling converter
`default_nettype none
module asq_sequencer_control (
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  reset,
  // module clock enable and halt
  input  wire logic                  converterClockEnable,
  input  wire logic                  halt,
  // register port
  input  wire asq_pkg::asq_bus_req_t busReq,
  output logic [15:0]                regRdData_q,
  // start triggers
  input  wire logic                  sequenceTriggerA,
  input  wire logic                  sequenceTriggerB,
  input  wire logic                  externalInterruptTwo,
  // analog core
  input  wire asq_pkg::asq_analog_t  analogIn,
  output logic [3:0]                 muxChannel_q,
  output logic                       sampleHold_q,
  output logic                       analogLowPower_q,
  // sequence end and interrupt requests
  output logic                       sequenceEndA_q,
  output logic                       sequenceEndB_q,
  output logic                       intReqA_q,
  output logic                       intReqB_q
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] base,
                               input logic [7:0] mask);
    return (a & mask) == base;
  endfunction

  asq_pkg::asq_ctrl_t     ctrl_q;
  asq_pkg::asq_prescale_t prescale_q;
  asq_pkg::asq_maxconv_t  maxConv_q;
  asq_pkg::asq_state_t    state_q;
  asq_pkg::asq_state_t    state_d;
  asq_pkg::asq_cmd_t      cmd;
  asq_pkg::asq_status_t   status;
  logic [3:0]             chSel_q [0:15];
  logic [11:0]            result_q [0:15];
  logic [3:0]             ptrA_q;
  logic [2:0]             ptrB_q;
  logic [3:0]             cntA_q;
  logic [2:0]             cntB_q;
  logic                   busyA_q;
  logic                   busyB_q;
  logic                   owner_q;
  logic                   eosTogA_q;
  logic                   eosTogB_q;
  logic [3:0]             divCnt_q;
  logic [3:0]             phaseCnt_q;
  logic [3:0]             phaseCnt_d;

  // the block is frozen while the module clock is off or halted, except analogLowPower_q, read data, end pulses and interrupts, which keep updating
  logic clkRun;
  assign clkRun = converterClockEnable & ~halt;

  // register decode
  logic wrEn;
  logic wrCtrl;
  logic wrCmd;
  logic wrPre;
  logic wrMax;
  logic wrChSel;
  logic [3:0] busSlot;
  assign wrEn    = busReq.write & clkRun;
  assign wrCtrl  = wrEn & hit(busReq.addr, asq_pkg::OFS_CTRL, asq_pkg::MASK_ONE);
  assign wrCmd   = wrEn & hit(busReq.addr, asq_pkg::OFS_CMD, asq_pkg::MASK_ONE);
  assign wrPre   = wrEn & hit(busReq.addr, asq_pkg::OFS_PRESCALE, asq_pkg::MASK_ONE);
  assign wrMax   = wrEn & hit(busReq.addr, asq_pkg::OFS_MAXCONV, asq_pkg::MASK_ONE);
  assign wrChSel = wrEn & hit(busReq.addr, asq_pkg::OFS_CHSEL, asq_pkg::MASK_BANK);
  assign busSlot = busReq.addr[3:0];
  assign cmd     = wrCmd ? asq_pkg::asq_cmd_t'(busReq.wdata[3:0]) : '0;

  // triggers
  logic trigA;
  logic trigB;
  assign trigA = cmd.swA | (ctrl_q.pwmEnA & sequenceTriggerA)
               | (ctrl_q.extEnA & externalInterruptTwo);
  assign trigB = ~ctrl_q.cascade
               & (cmd.swB | (ctrl_q.pwmEnB & sequenceTriggerB));

  // slot and channel selection
  logic [3:0] slotA;
  logic [3:0] slotB;
  logic [3:0] startSlot;
  logic [3:0] curSlot;
  logic [3:0] selCh;
  logic [3:0] startCh;
  logic       startAny;
  assign slotA     = ctrl_q.cascade ? ptrA_q : {1'b0, ptrA_q[2:0]};
  assign slotB     = {1'b1, ptrB_q};
  // sequencer A always wins when both wait; B only gets the core between A sessions
  assign startAny  = (state_q == asq_pkg::ST_IDLE) & (busyA_q | busyB_q) & clkRun;
  assign startSlot = busyA_q ? slotA : slotB;
  assign curSlot   = owner_q ? slotB : slotA;
  assign selCh     = chSel_q[startSlot];
  assign startCh   = ctrl_q.cascade ? selCh : {~busyA_q, selCh[2:0]};

  // converter clock prescaler and phase timing
  logic tick;
  logic acqDone;
  logic convDone;
  logic store;
  assign tick     = clkRun & (divCnt_q == prescale_q.clkDiv);
  assign acqDone  = tick & (phaseCnt_q == prescale_q.acqPs);
  assign convDone = tick & (phaseCnt_q == asq_pkg::CONV_LAST);
  assign store    = clkRun & (state_q == asq_pkg::ST_STORE);

  always_comb begin
    state_d    = state_q;
    phaseCnt_d = phaseCnt_q;
    case (state_q)
      asq_pkg::ST_IDLE: begin
        phaseCnt_d = 4'h0;
        if (startAny) begin
          state_d = asq_pkg::ST_ACQ;
        end
      end
      asq_pkg::ST_ACQ: begin
        if (acqDone) begin
          state_d    = asq_pkg::ST_CONV;
          phaseCnt_d = 4'h0;
        end else if (tick) begin
          phaseCnt_d = phaseCnt_q + 4'h1;
        end
      end
      asq_pkg::ST_CONV: begin
        if (convDone) begin
          state_d    = asq_pkg::ST_STORE;
          phaseCnt_d = 4'h0;
        end else if (tick) begin
          phaseCnt_d = phaseCnt_q + 4'h1;
        end
      end
      asq_pkg::ST_STORE: begin
        if (clkRun) begin
          state_d = asq_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d    = asq_pkg::ST_IDLE;
        phaseCnt_d = 4'h0;
      end
    endcase
  end

  // transfer function
  logic [15:0] diffMv;
  logic [27:0] scaled;
  logic [27:0] quot;
  logic [11:0] code;
  logic        atLow;
  logic        atFull;
  assign diffMv = analogIn.inputMv - analogIn.lowRefMv;
  assign scaled = {diffMv, 12'h000};
  assign quot   = scaled / {12'h000, asq_pkg::FULL_SCALE_MV};
  assign atLow  = analogIn.inputMv <= analogIn.lowRefMv;
  assign atFull = analogIn.inputMv >= asq_pkg::FULL_SCALE_MV;
  assign code   = atLow ? asq_pkg::CODE_ZERO
                : atFull ? asq_pkg::CODE_MAX : quot[11:0];

  // session bookkeeping
  logic [3:0] maxA;
  logic       lastA;
  logic       lastB;
  logic       endA;
  logic       endB;
  logic [3:0] advA;
  assign maxA  = ctrl_q.cascade ? maxConv_q.maxA : {1'b0, maxConv_q.maxA[2:0]};
  assign lastA = cntA_q == maxA;
  assign lastB = cntB_q == maxConv_q.maxB;
  assign endA  = store & ~owner_q & lastA;
  assign endB  = store & owner_q & lastB;
  assign advA  = ctrl_q.cascade ? ptrA_q + 4'h1 : {1'b0, ptrA_q[2:0] + 3'h1};

  // configuration registers; reset runs regardless of the enable
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ctrl_q     <= asq_pkg::CTRL_RST;
      prescale_q <= asq_pkg::PRESCALE_RST;
      maxConv_q  <= asq_pkg::MAXCONV_RST;
    end else begin
      if (wrCtrl) ctrl_q <= asq_pkg::asq_ctrl_t'(busReq.wdata[7:0]);
      if (wrPre) prescale_q <= asq_pkg::asq_prescale_t'(busReq.wdata[7:0]);
      if (wrMax) maxConv_q <= asq_pkg::asq_maxconv_t'(busReq.wdata[7:0]);
    end
  end

  // per-slot channel selects and result registers
  genvar s;
  generate
    for (s = 0; s < 16; s++) begin : gSlot
      always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
          chSel_q[s]  <= 4'h0;
          result_q[s] <= 12'h000;
        end else begin
          if (wrChSel && busSlot == 4'(s)) chSel_q[s] <= busReq.wdata[3:0];
          if (store && curSlot == 4'(s)) result_q[s] <= code;
        end
      end
    end
  endgenerate

  // converter timing
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q    <= asq_pkg::ST_IDLE;
      phaseCnt_q <= 4'h0;
      divCnt_q   <= 4'h0;
    end else if (clkRun) begin
      state_q    <= state_d;
      phaseCnt_q <= phaseCnt_d;
      divCnt_q   <= tick ? 4'h0 : divCnt_q + 4'h1;
    end
  end

  // sequencer A
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ptrA_q    <= 4'h0;
      cntA_q    <= 4'h0;
      busyA_q   <= 1'b0;
      eosTogA_q <= 1'b0;
    end else if (cmd.rstA) begin
      ptrA_q    <= 4'h0;
      cntA_q    <= 4'h0;
      busyA_q   <= 1'b0;
      eosTogA_q <= 1'b0;
    end else if (clkRun) begin
      busyA_q <= trigA | (busyA_q & ~endA);
      if (store && !owner_q) begin
        cntA_q <= lastA ? 4'h0 : cntA_q + 4'h1;
        ptrA_q <= (lastA && !ctrl_q.startStop) ? 4'h0 : advA;
      end
      if (endA) eosTogA_q <= ~eosTogA_q;
    end
  end

  // sequencer B
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ptrB_q    <= 3'h0;
      cntB_q    <= 3'h0;
      busyB_q   <= 1'b0;
      eosTogB_q <= 1'b0;
    end else if (cmd.rstB) begin
      ptrB_q    <= 3'h0;
      cntB_q    <= 3'h0;
      busyB_q   <= 1'b0;
      eosTogB_q <= 1'b0;
    end else if (clkRun) begin
      busyB_q <= trigB | (busyB_q & ~endB);
      if (store && owner_q) begin
        cntB_q <= lastB ? 3'h0 : cntB_q + 3'h1;
        ptrB_q <= (lastB && !ctrl_q.startStop) ? 3'h0 : ptrB_q + 3'h1;
      end
      if (endB) eosTogB_q <= ~eosTogB_q;
    end
  end

  // analog core drive
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      owner_q          <= 1'b0;
      muxChannel_q     <= 4'h0;
      sampleHold_q     <= 1'b0;
      analogLowPower_q <= 1'b1;
    end else begin
      analogLowPower_q <= ~converterClockEnable | halt;
      if (clkRun) begin
        if (startAny) begin
          owner_q      <= ~busyA_q;
          muxChannel_q <= startCh;
        end
        sampleHold_q <= (state_d == asq_pkg::ST_ACQ);
      end
    end
  end

  // end-of-sequence pulses and interrupt requests
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sequenceEndA_q <= 1'b0;
      sequenceEndB_q <= 1'b0;
      intReqA_q      <= 1'b0;
      intReqB_q      <= 1'b0;
    end else begin
      sequenceEndA_q <= endA;
      sequenceEndB_q <= endB;
      intReqA_q      <= endA & (~ctrl_q.everyOtherA | eosTogA_q);
      intReqB_q      <= endB & (~ctrl_q.everyOtherB | eosTogB_q);
    end
  end

  // register read, answered one cycle after the strobe
  logic [15:0] rdMux;
  assign status = '{spare1: 1'b0, ptrB: ptrB_q, ptrA: ptrA_q, spare0: 3'h0,
                    state: state_q, owner: owner_q, busyB: busyB_q, busyA: busyA_q};
  assign rdMux =
    hit(busReq.addr, asq_pkg::OFS_CTRL, asq_pkg::MASK_ONE) ? {8'h00, ctrl_q} :
    hit(busReq.addr, asq_pkg::OFS_PRESCALE, asq_pkg::MASK_ONE) ? {8'h00, prescale_q} :
    hit(busReq.addr, asq_pkg::OFS_MAXCONV, asq_pkg::MASK_ONE) ? {8'h00, maxConv_q} :
    hit(busReq.addr, asq_pkg::OFS_STATUS, asq_pkg::MASK_ONE) ? status :
    hit(busReq.addr, asq_pkg::OFS_CHSEL, asq_pkg::MASK_BANK) ? {12'h000, chSel_q[busSlot]} :
    hit(busReq.addr, asq_pkg::OFS_RESULT, asq_pkg::MASK_BANK) ? {4'h0, result_q[busSlot]} :
    16'h0000;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      regRdData_q <= 16'h0000;
    end else begin
      regRdData_q <= (busReq.read & clkRun) ? rdMux : 16'h0000;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  chk_code_low_zero: assert property (
    store && atLow |=> result_q[$past(curSlot)] == 12'h000)
    else $error("low input did not store zero");

  chk_code_full_sat: assert property (
    store && !atLow && atFull |=> result_q[$past(curSlot)] == 12'hfff)
    else $error("full scale input did not saturate");

  chk_code_floor_scale: assert property (
    store && !atLow && !atFull |->
      ({16'h0000, code} * 28'hbb8 <= scaled) && (({16'h0000, code} + 28'h1) * 28'hbb8 > scaled))
    else $error("code is not the truncated ratio");

  chk_dual_channel_group: assert property (
    sampleHold_q && !ctrl_q.cascade |-> muxChannel_q[3] == owner_q)
    else $error("dual sequencer left its own channel group");

  chk_owner_held_busy: assert property (
    clkRun && state_q != asq_pkg::ST_IDLE |=> owner_q == $past(owner_q))
    else $error("converter owner changed mid conversion");

  chk_first_slot_return: assert property (
    endA && !ctrl_q.startStop |=> ptrA_q == 4'h0 && !busyA_q)
    else $error("sequencer A did not return to first slot");

  chk_every_end_irq: assert property (
    endA && !ctrl_q.everyOtherA |=> intReqA_q && sequenceEndA_q)
    else $error("interrupt missing on sequence end");

  chk_alt_end_irq: assert property (
    endA && ctrl_q.everyOtherA && !eosTogA_q |=> !intReqA_q ##0 sequenceEndA_q)
    else $error("interrupt raised on odd sequence end");

  chk_halt_freeze: assert property (
    halt |=> $stable(state_q) && $stable(ptrA_q) && $stable(ctrl_q))
    else $error("logic moved during halt");

  chk_lowpow_disabled: assert property (
    !converterClockEnable |=> analogLowPower_q)
    else $error("analog core awake without module clock");

endmodule
`default_nettype wire

// ==== asq_pkg.sv ====
// shared types, register map and timing constants of the converter sequencer
`default_nettype none
package asq_pkg;
  // timing
  localparam int CLK_MHZ      = 10;
  localparam int CONV_TIME_NS = 80;
  localparam int CONV_CYC_RAW = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int CONV_CYCLES  = (CONV_CYC_RAW < 1) ? 1 : CONV_CYC_RAW;
  localparam logic [3:0] CONV_LAST = 4'(CONV_CYCLES - 1);

  // transfer function
  localparam logic [15:0] FULL_SCALE_MV = 16'hbb8;
  localparam logic [11:0] CODE_MAX      = 12'hfff;
  localparam logic [11:0] CODE_ZERO     = 12'h000;

  // register offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_CMD      = 8'h01;
  localparam logic [7:0] OFS_PRESCALE = 8'h02;
  localparam logic [7:0] OFS_MAXCONV  = 8'h03;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_CHSEL    = 8'h10;
  localparam logic [7:0] OFS_RESULT   = 8'h20;
  localparam logic [7:0] MASK_ONE     = 8'hff;
  localparam logic [7:0] MASK_BANK    = 8'hf0;

  typedef struct packed {
    logic everyOtherB;
    logic everyOtherA;
    logic extEnA;
    logic pwmEnB;
    logic pwmEnA;
    logic startStop;
    logic cascade;
    logic spare;
  } asq_ctrl_t;

  typedef struct packed {
    logic rstB;
    logic rstA;
    logic swB;
    logic swA;
  } asq_cmd_t;

  typedef struct packed {
    logic [3:0] acqPs;
    logic [3:0] clkDiv;
  } asq_prescale_t;

  typedef struct packed {
    logic       spare;
    logic [2:0] maxB;
    logic [3:0] maxA;
  } asq_maxconv_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ACQ   = 2'b01,
    ST_CONV  = 2'b10,
    ST_STORE = 2'b11
  } asq_state_t;

  typedef struct packed {
    logic       spare1;
    logic [2:0] ptrB;
    logic [3:0] ptrA;
    logic [2:0] spare0;
    asq_state_t state;
    logic       owner;
    logic       busyB;
    logic       busyA;
  } asq_status_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        write;
    logic        read;
  } asq_bus_req_t;

  typedef struct packed {
    logic [15:0] inputMv;
    logic [15:0] lowRefMv;
  } asq_analog_t;

  // reset values
  localparam asq_ctrl_t     CTRL_RST     = '0;
  localparam asq_prescale_t PRESCALE_RST = '0;
  localparam asq_maxconv_t  MAXCONV_RST  = '0;
endpackage
`default_nettype wire

// ==== asq_analog_model.sv ====
// analog core stand-in: drives the converter input from a per-channel voltage table
`default_nettype none
module asq_analog_model (
  // channel voltages and reference set by the bench
  input  wire logic [15:0]      chanMv [16],
  input  wire logic [15:0]      lowRefMv,
  // mux and power state from the sequencer
  input  wire logic [3:0]       muxChannel_q,
  input  wire logic             analogLowPower_q,
  // converter input
  output var asq_pkg::asq_analog_t analogIn
);
  timeunit 1ns;
  timeprecision 1ns;
  // a powered-down core holds no valid sample, so show the inverted level
  assign analogIn = '{inputMv:  analogLowPower_q ? ~chanMv[muxChannel_q] : chanMv[muxChannel_q],
                      lowRefMv: lowRefMv};
endmodule
`default_nettype wire

// ==== asq_sequencer_control_tb.sv ====
// self-checking bench for the converter sequencer control
`default_nettype none
module asq_sequencer_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] LO_MV = 16'h0014;
  logic                  core_clk = 1'b0;
  logic                  reset = 1'b1;
  logic                  converterClockEnable = 1'b0;
  logic                  halt = 1'b0;
  asq_pkg::asq_bus_req_t busReq = '0;
  logic                  sequenceTriggerA = 1'b0;
  logic                  sequenceTriggerB = 1'b0;
  logic                  externalInterruptTwo = 1'b0;
  asq_pkg::asq_analog_t  analogIn;
  logic [15:0]           regRdData_q;
  logic [3:0]            muxChannel_q;
  logic                  sampleHold_q;
  logic                  analogLowPower_q;
  logic                  sequenceEndA_q;
  logic                  sequenceEndB_q;
  logic                  intReqA_q;
  logic                  intReqB_q;
  logic [15:0]           chanMv [16];
  logic [3:0]            slotCh [16];
  logic                  cascadeMode = 1'b0;
  int mismatches = 0, n_compared = 0, nEndA = 0, nEndB = 0, nIntA = 0, nIntB = 0;
  int shLen = 0, shLast = 0;
  localparam logic [7:0] base_ofs [4] = '{8'h00, 8'h02, 8'h03, 8'h04};
  localparam int dualSlots [4] = '{0, 1, 8, 9};

  always #50 core_clk = ~core_clk;

  asq_sequencer_control DUT (
    .core_clk(core_clk), .reset(reset), .converterClockEnable(converterClockEnable),
    .halt(halt), .busReq(busReq), .regRdData_q(regRdData_q),
    .sequenceTriggerA(sequenceTriggerA), .sequenceTriggerB(sequenceTriggerB),
    .externalInterruptTwo(externalInterruptTwo), .analogIn(analogIn),
    .muxChannel_q(muxChannel_q), .sampleHold_q(sampleHold_q),
    .analogLowPower_q(analogLowPower_q), .sequenceEndA_q(sequenceEndA_q),
    .sequenceEndB_q(sequenceEndB_q), .intReqA_q(intReqA_q), .intReqB_q(intReqB_q));

  asq_analog_model core (
    .chanMv(chanMv), .lowRefMv(LO_MV), .muxChannel_q(muxChannel_q),
    .analogLowPower_q(analogLowPower_q), .analogIn(analogIn));

  // pulse counters and acquisition window length in clock cycles
  always @(posedge core_clk) begin
    if (sequenceEndA_q === 1'b1) nEndA++;
    if (sequenceEndB_q === 1'b1) nEndB++;
    if (intReqA_q === 1'b1) nIntA++;
    if (intReqB_q === 1'b1) nIntB++;
    if (sampleHold_q === 1'b1) shLen++;
    else if (shLen != 0) begin
      shLast = shLen;
      shLen = 0;
    end
  end

  function automatic logic [15:0] code_of(input logic [15:0] mv);
    if (mv <= LO_MV) return 16'h0000;
    if (mv >= asq_pkg::FULL_SCALE_MV) return {4'h0, asq_pkg::CODE_MAX};
    return 16'((32'(mv - LO_MV) * 32'h1000) / 32'(asq_pkg::FULL_SCALE_MV));
  endfunction

  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t ns %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    busReq <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
    @(posedge core_clk);
    busReq.write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk);
    busReq <= '{addr: a, wdata: 16'h0000, write: 1'b0, read: 1'b1};
    @(posedge core_clk);
    busReq.read <= 1'b0;
    #1 d = regRdData_q;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp, input string what);
    logic [15:0] v;
    rd(a, v);
    check(v, exp, what);
  endtask

  task automatic set_ch(input int n, input logic [3:0] c);
    slotCh[n] = c;
    wr(asq_pkg::OFS_CHSEL + 8'(n), {12'h000, c});
  endtask

  task automatic chk_slot(input int n);
    logic [3:0] ch;
    ch = cascadeMode ? slotCh[n] : {n[3], slotCh[n][2:0]};
    rdchk(asq_pkg::OFS_RESULT + 8'(n), code_of(chanMv[ch]), "result");
  endtask

  task automatic chk_ptr_a(input logic [3:0] exp);
    logic [15:0] v;
    rd(asq_pkg::OFS_STATUS, v);
    check({12'h000, v[11:8]}, {12'h000, exp}, "slot pointer A");
  endtask

  task automatic wait_ends(input int ea, input int eb);
    for (int i = 0; i < 4000; i++) begin
      @(posedge core_clk);
      #1;
      if (nEndA >= ea && nEndB >= eb) return;
    end
    mismatches++;
    $display("[ERR] %0t ns timeout waiting for sequence end", $time);
    print_verdict();
  endtask

  task automatic pulse(input logic a, input logic b, input logic x);
    @(posedge core_clk);
    sequenceTriggerA <= a;
    sequenceTriggerB <= b;
    externalInterruptTwo <= x;
    @(posedge core_clk);
    {sequenceTriggerA, sequenceTriggerB, externalInterruptTwo} <= 3'h0;
  endtask

  initial begin
    int base;
    for (int i = 0; i < 16; i++) chanMv[i] = 16'(i) * 16'h00b3 + 16'h0015;
    chanMv[0] = 16'h000a;
    chanMv[1] = 16'h0014;
    chanMv[2] = 16'h0bb8;
    chanMv[3] = 16'h0dac;
    chanMv[4] = 16'h0015;
    chanMv[5] = 16'h0bb7;
    repeat (12) @(posedge core_clk);
    #1 check({15'h0, analogLowPower_q}, 16'h0001, "low power in reset");
    reset <= 1'b0;
    wr(asq_pkg::OFS_CTRL, 16'h0002);
    #1 check({15'h0, analogLowPower_q}, 16'h0001, "low power while gated");
    converterClockEnable <= 1'b1;
    repeat (100) @(posedge core_clk);
    check({15'h0, analogLowPower_q}, 16'h0000, "core on after enable");
    rdchk(asq_pkg::OFS_CTRL, 16'h0000, "gated write lost");
    foreach (base_ofs[i]) rdchk(base_ofs[i], 16'h0000, "reset value");
    rdchk(8'h05, 16'h0000, "unmapped read");
    $display("test 1 reset and gating done");

    // cascade, 16 slots with a repeated channel, slow prescale
    cascadeMode = 1'b1;
    wr(asq_pkg::OFS_CTRL, 16'h0002);
    wr(asq_pkg::OFS_PRESCALE, 16'h0021);
    rdchk(asq_pkg::OFS_PRESCALE, 16'h0021, "prescale readback");
    wr(asq_pkg::OFS_MAXCONV, 16'h000f);
    for (int n = 0; n < 16; n++) set_ch(n, (n > 13) ? 4'h3 : 4'(n * 5));
    base = nIntA;
    wr(asq_pkg::OFS_CMD, 16'h0001);
    wait_ends(nEndA + 1, nEndB);
    for (int n = 0; n < 16; n++) chk_slot(n);
    check(16'(shLast), 16'h0006, "acquisition window");
    check(16'(nIntA - base), 16'h0001, "interrupt per end");
    chk_ptr_a(4'h0);
    $display("test 2 cascade session done");

    // dual mode, pwm triggers together, then external pin
    cascadeMode = 1'b0;
    wr(asq_pkg::OFS_CTRL, 16'h0038);
    wr(asq_pkg::OFS_PRESCALE, 16'h0000);
    wr(asq_pkg::OFS_MAXCONV, 16'h0011);
    set_ch(0, 4'hb);
    set_ch(1, 4'h2);
    set_ch(8, 4'h1);
    set_ch(9, 4'h5);
    pulse(1'b1, 1'b1, 1'b0);
    wait_ends(nEndA + 1, nEndB + 1);
    foreach (dualSlots[i]) chk_slot(dualSlots[i]);
    check(16'(shLast), 16'h0001, "fastest window");
    check(16'(nIntB), 16'h0001, "interrupt B per end");
    set_ch(0, 4'h4);
    pulse(1'b0, 1'b0, 1'b1);
    wait_ends(nEndA + 1, nEndB);
    chk_slot(0);
    chk_slot(8);
    $display("test 3 dual triggers done");

    // every second end raises the interrupt
    wr(asq_pkg::OFS_CTRL, 16'h0048);
    wr(asq_pkg::OFS_CMD, 16'h0004);
    base = nIntA;
    pulse(1'b1, 1'b0, 1'b0);
    wait_ends(nEndA + 1, nEndB);
    check(16'(nIntA - base), 16'h0000, "first end silent");
    pulse(1'b1, 1'b0, 1'b0);
    wait_ends(nEndA + 1, nEndB);
    check(16'(nIntA - base), 16'h0001, "second end raises");
    $display("test 4 every other end done");

    // start/stop: each trigger continues from where the last stopped
    wr(asq_pkg::OFS_CTRL, 16'h0004);
    wr(asq_pkg::OFS_MAXCONV, 16'h0001);
    wr(asq_pkg::OFS_CMD, 16'h0004);
    set_ch(2, 4'hd);
    set_ch(3, 4'h2);
    wr(asq_pkg::OFS_CMD, 16'h0001);
    wait_ends(nEndA + 1, nEndB);
    chk_ptr_a(4'h2);
    wr(asq_pkg::OFS_CMD, 16'h0001);
    wait_ends(nEndA + 1, nEndB);
    chk_ptr_a(4'h4);
    chk_slot(2);
    chk_slot(3);
    $display("test 5 start stop done");

    // halt freezes registers and powers the core down
    halt <= 1'b1;
    rdchk(asq_pkg::OFS_CTRL, 16'h0000, "read during halt");
    check({15'h0, analogLowPower_q}, 16'h0001, "low power in halt");
    halt <= 1'b0;
    rdchk(asq_pkg::OFS_CTRL, 16'h0004, "control kept over halt");
    chk_slot(3);
    $display("test 6 halt done");
    print_verdict();
  end
endmodule
`default_nettype wire
